// *** dmarr_pkg.sv ***
// Constants and carrier types for the DMA register read-request port.
package dmarr_pkg;

    // ------------------------------------------------------------------
    // Register offsets on the bus (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0]  DMARR_OFS_REQUEST = 8'h00;
    localparam logic [7:0]  DMARR_OFS_RESULT  = 8'h04;
    localparam logic [7:0]  DMARR_OFS_STATUS  = 8'h08;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          DMARR_REQ_BIT     = 31;
    localparam int          DMARR_ABORT_BIT   = 30;
    localparam int          DMARR_SEL_MSB     = 7;
    localparam int          DMARR_SEL_LSB     = 2;
    localparam int          DMARR_SEL_W       = 6;
    localparam int          DMARR_DONE_BIT    = 0;
    localparam int          DMARR_BADSEL_BIT  = 1;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [31:0] DMARR_RST_REQUEST = 32'h0000_0000;
    localparam logic [31:0] DMARR_RST_RESULT  = 32'h0000_0000;
    localparam logic [5:0]  DMARR_RST_SEL     = 6'h00;

    // ------------------------------------------------------------------
    // Offsets of the internal registers that software may select
    // ------------------------------------------------------------------
    localparam logic [7:0]  DMARR_TGT_MW_ADDR = 8'h48;
    localparam logic [7:0]  DMARR_TGT_MR_ADDR = 8'h58;
    localparam logic [7:0]  DMARR_TGT_TIMEOUT = 8'h88;

    // ------------------------------------------------------------------
    // Timing of the forced cancellation
    // ------------------------------------------------------------------
    localparam int          DMARR_CLK_NS      = 10;
    localparam int          DMARR_ABORT_NS    = 20;
    localparam logic [3:0]  DMARR_ABORT_CYC   =
        4'((DMARR_ABORT_NS + DMARR_CLK_NS - 1) / DMARR_CLK_NS);

    // ------------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        DMARR_IDLE,
        DMARR_READ,
        DMARR_ABORT
    } dmarr_state_e;

    typedef struct packed {
        logic        valid;
        logic        cancel;
        logic [7:0]  addr;
    } dmarr_core_req_s;

    typedef struct packed {
        logic        ack;
        logic [31:0] data;
    } dmarr_core_rsp_s;

endpackage

// *** dmarr_sticky.sv ***
// Sticky status flag whose hardware set wins over a software clear.
`timescale 1ns/10ps
module dmarr_sticky
    import dmarr_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_ni,
    input  wire logic set_i,
    input  wire logic clr_i,
    output logic      flag_o
);

    logic flag_d;
    logic flag_q;

    // A set in the same cycle as a clear keeps the flag high.
    assign flag_d = set_i | (flag_q & ~clr_i);

    // Flag storage.
    always_ff @(posedge clk_i or negedge rst_ni) begin
        if (!rst_ni) begin
            flag_q <= 1'b0;
        end else begin
            flag_q <= flag_d;
        end
    end

    assign flag_o = flag_q;

endmodule

// *** dmarr_top.sv ***
// Indirect read port for internal DMA registers, on classic Wishbone.
//
// What this block does
// - Writing request one launches selected register read.
// - Completion stores value, clears request, flags done.
// - Writing abort one cancels request, clears it.
// - Abort bit clears itself after cancellation.
// - Selector sits in bits 7..2, upper offset.
//
// Added by the designer: the Wishbone register port and the address map.
`timescale 1ns/10ps
module dmarr_top
    import dmarr_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [7:0]       wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    output dmarr_core_req_s       core_req_o,
    input  wire dmarr_core_rsp_s  core_rsp_i
);

    // ------------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;

    // Release the asynchronous reset through two flip-flops. Only the
    // second flop is read by the rest of the block, so a release that
    // lands near a clock edge never reaches the logic half-settled.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Bus access decode
    // ------------------------------------------------------------------
    logic        ack_q;
    logic        access;
    logic        commit;
    logic        wr_access;
    logic        hit_request;
    logic        hit_result;
    logic        hit_status;
    logic        wr_request;
    logic        wr_status;

    // An access is taken in the first cycle of a strobe, before ack.
    // Read data is captured there, so it stands with the ack that
    // follows; the registered ack costs one wait state per transfer.
    assign access      = wb_cyc_i & wb_stb_i & ~ack_q;
    // A write lands only at the edge where the master samples ack
    // high, so a request abandoned before ack changes nothing.
    assign commit      = wb_cyc_i & wb_stb_i & ack_q;
    assign wr_access   = commit & wb_we_i;
    // Register decode on the full byte address.
    assign hit_request = (wb_adr_i == DMARR_OFS_REQUEST);
    assign hit_result  = (wb_adr_i == DMARR_OFS_RESULT);
    assign hit_status  = (wb_adr_i == DMARR_OFS_STATUS);
    assign wr_request  = wr_access & hit_request;
    assign wr_status   = wr_access & hit_status;

    // ------------------------------------------------------------------
    // Write data of the request register, split by byte lane
    // ------------------------------------------------------------------
    logic        wr_req_one;
    logic        wr_abort_one;
    logic        wr_sel_lane;
    logic [5:0]  wr_sel_val;

    // Control bits live in lane 3, the selector in lane 0. A write to
    // lane 3 alone keeps the stored selector, so software can repeat a
    // read of the same target without rewriting it.
    assign wr_req_one   = wr_request & wb_sel_i[3] & wb_dat_i[DMARR_REQ_BIT];
    assign wr_abort_one = wr_request & wb_sel_i[3]
                        & wb_dat_i[DMARR_ABORT_BIT];
    assign wr_sel_lane  = wr_request & wb_sel_i[0];
    assign wr_sel_val   = wb_dat_i[DMARR_SEL_MSB:DMARR_SEL_LSB];

    // ------------------------------------------------------------------
    // Read sequencer state
    // ------------------------------------------------------------------
    dmarr_state_e    state_q;
    dmarr_state_e    state_d;
    logic [5:0]      sel_q;
    logic [5:0]      sel_d;
    logic [3:0]      abort_cnt_q;
    logic [3:0]      abort_cnt_d;
    logic [31:0]     result_q;
    logic [31:0]     result_d;
    logic            start_read;
    logic            start_abort;
    logic            read_done;
    logic            abort_done;
    logic [7:0]      target_addr;
    logic            target_legal;

    // A write of one launches a read; zeros in the bits do nothing.
    // launch on request
    assign start_read  = wr_req_one & ~wr_abort_one
                       & (state_q == DMARR_IDLE);
    // Abort wins over everything, even a simultaneous request.
    // Software should never do both at once; this only makes it safe.
    // abort cancels request
    assign start_abort = wr_abort_one & (state_q != DMARR_ABORT);
    assign read_done   = (state_q == DMARR_READ) & core_rsp_i.ack
                       & ~start_abort;
    assign abort_done  = (state_q == DMARR_ABORT) & (abort_cnt_q == 4'h1);

    // The selector is written only while no read is outstanding, so
    // the address towards the core cannot change under a pending read.
    // selector bits seven to two
    assign sel_d = (wr_sel_lane && state_q == DMARR_IDLE) ? wr_sel_val
                                                          : sel_q;

    // Byte offset of the internal register: selector above two zeros.
    assign target_addr  = {sel_d, 2'b00};
    // Flags a selector outside the permitted set; the read still runs.
    // permitted offsets check
    assign target_legal = (target_addr == DMARR_TGT_MW_ADDR)
                        | (target_addr == DMARR_TGT_MR_ADDR)
                        | (target_addr == DMARR_TGT_TIMEOUT);

    // Next-state logic of the sequencer. The abort counter runs only
    // in the abort state; its load value sets how many cycles the
    // cancel is held towards the core before the port is free again.
    always_comb begin
        state_d     = state_q;
        abort_cnt_d = abort_cnt_q;
        case (state_q)
            DMARR_IDLE: begin
                if (start_abort) begin
                    state_d     = DMARR_ABORT;
                    abort_cnt_d = DMARR_ABORT_CYC;
                end else if (start_read) begin
                    state_d = DMARR_READ;
                end
            end
            DMARR_READ: begin
                if (start_abort) begin
                    state_d     = DMARR_ABORT;
                    abort_cnt_d = DMARR_ABORT_CYC;
                end else if (read_done) begin
                    state_d = DMARR_IDLE;
                end
            end
            DMARR_ABORT: begin
                abort_cnt_d = abort_cnt_q - 4'h1;
                if (abort_done) begin
                    state_d = DMARR_IDLE;
                end
            end
            default: begin
                state_d     = DMARR_IDLE;
                abort_cnt_d = 4'h0;
            end
        endcase
    end

    // The result only moves on a completed read, never on a cancel.
    // A core answer that arrives during a cancel is dropped here.
    // keep last value
    assign result_d = read_done ? core_rsp_i.data : result_q;

    // Sequencer registers.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            state_q     <= DMARR_IDLE;
            sel_q       <= DMARR_RST_SEL;
            abort_cnt_q <= 4'h0;
            result_q    <= DMARR_RST_RESULT;
        end else begin
            state_q     <= state_d;
            sel_q       <= sel_d;
            abort_cnt_q <= abort_cnt_d;
            result_q    <= result_d;
        end
    end

    // ------------------------------------------------------------------
    // Port to the internal DMA registers
    // ------------------------------------------------------------------
    dmarr_core_req_s core_req_d;
    dmarr_core_req_s core_req_q;

    // Request is held while reading; cancel is held while aborting.
    // The address follows the selector even while idle; the core only
    // looks at it while valid is high, and it cannot move during a read.
    // drive core read
    assign core_req_d.valid  = (state_d == DMARR_READ);
    assign core_req_d.cancel = (state_d == DMARR_ABORT);
    assign core_req_d.addr   = target_addr;

    // Registered so the core sees clean, glitch-free levels.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            core_req_q <= '0;
        end else begin
            core_req_q <= core_req_d;
        end
    end

    assign core_req_o = core_req_q;

    // ------------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------------
    logic done_flag;
    logic badsel_flag;
    logic clr_done;
    logic clr_badsel;

    // Software clears a flag by writing one to it in lane 0.
    assign clr_done   = wr_status & wb_sel_i[0] & wb_dat_i[DMARR_DONE_BIT];
    assign clr_badsel = wr_status & wb_sel_i[0]
                      & wb_dat_i[DMARR_BADSEL_BIT];

    // Read-done flag, set when a read completes. A completion in the
    // same cycle as a software clear keeps the flag set, so software
    // never misses the end of a read.
    // set done flag
    dmarr_sticky u_done_flag (
        .clk_i  (clk_i),
        .rst_ni (rst_n_q),
        .set_i  (read_done),
        .clr_i  (clr_done),
        .flag_o (done_flag)
    );

    // Selector-outside-permitted-set flag, set at launch.
    // The read still runs; the flag only tells software it chose badly.
    dmarr_sticky u_badsel_flag (
        .clk_i  (clk_i),
        .rst_ni (rst_n_q),
        .set_i  (start_read & ~target_legal),
        .clr_i  (clr_badsel),
        .flag_o (badsel_flag)
    );

    // ------------------------------------------------------------------
    // Read-back values
    // ------------------------------------------------------------------
    logic        busy_read;
    logic        busy_abort;
    logic [31:0] request_view;
    logic [31:0] status_view;
    logic [31:0] rd_mux;

    // Pending and cancelling as seen by software.
    assign busy_read  = (state_q == DMARR_READ);
    assign busy_abort = (state_q == DMARR_ABORT);

    // Request bit reads one while a read is pending, abort while
    // cancelling; both return to zero on their own.
    // self-clearing request
    assign request_view = DMARR_RST_REQUEST
                        | ({31'h0, busy_read} << DMARR_REQ_BIT)
                        | ({31'h0, busy_abort} << DMARR_ABORT_BIT)
                        | ({26'h0, sel_q} << DMARR_SEL_LSB);

    assign status_view  = ({31'h0, done_flag} << DMARR_DONE_BIT)
                        | ({31'h0, badsel_flag} << DMARR_BADSEL_BIT);

    // Unmapped addresses and reserved bits read as zero, so software
    // never sees stale state through an unused field.
    assign rd_mux = hit_request ? request_view :
                    hit_result  ? result_q     :
                    hit_status  ? status_view  : 32'h0000_0000;

    // ------------------------------------------------------------------
    // Bus answer
    // ------------------------------------------------------------------
    logic [31:0] dat_q;

    // Ack comes one cycle after the strobe and falls the cycle after.
    // Read data is zero outside a read, so the bus idles at zeros.
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= access;
            dat_q <= (access && !wb_we_i) ? rd_mux : 32'h0000_0000;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

endmodule

// *** dmarr_top_checker.sv ***
// Assertions on the bus and core ports of the DMA read-request port.
`timescale 1ns/10ps
module dmarr_top_checker
    import dmarr_pkg::*;
(
    input wire logic            clk_i,
    input wire logic            rstn_i,
    input wire logic            wb_cyc_i,
    input wire logic            wb_stb_i,
    input wire logic            wb_we_i,
    input wire logic [7:0]      wb_adr_i,
    input wire logic [3:0]      wb_sel_i,
    input wire logic [31:0]     wb_dat_i,
    input wire logic [31:0]     wb_dat_o,
    input wire logic            wb_ack_o,
    input wire dmarr_core_req_s core_req_o,
    input wire dmarr_core_rsp_s core_rsp_i
);
    // ----------------------------------------------------------------
    // Decoded events
    // ----------------------------------------------------------------
    logic [31:0] last_q;
    // A bus request is taken on an edge where ack is still low.
    wire taken    = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write lands at the edge where ack is sampled high.
    wire commit   = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire req_wr   = commit & wb_we_i & (wb_adr_i == DMARR_OFS_REQUEST);
    wire abort_wr = req_wr & wb_sel_i[3] & wb_dat_i[30];
    wire start_wr = req_wr & wb_sel_i[3] & wb_sel_i[0] & wb_dat_i[31]
                    & ~wb_dat_i[30];
    wire zero_wr  = req_wr & wb_sel_i[3] & ~wb_dat_i[31] & ~wb_dat_i[30];
    wire idle     = ~core_req_o.valid & ~core_req_o.cancel;
    wire done     = core_req_o.valid & core_rsp_i.ack & ~abort_wr;
    wire res_rd   = taken & ~wb_we_i & (wb_adr_i == DMARR_OFS_RESULT)
                    & ~(core_req_o.valid & core_rsp_i.ack);

    // Mirror of the result register; only a completed read moves it.
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            last_q <= DMARR_RST_RESULT;
        end else if (done) begin
            last_q <= core_rsp_i.data;
        end
    end

    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    property p_ack_once; taken |=> wb_ack_o ##1 !wb_ack_o; endproperty
    a_ack_once: assert property (p_ack_once)
        else $error("Bus ack is not a single pulse.");
    property p_req_launch;
        start_wr && idle |=> core_req_o.valid && !core_req_o.cancel
            && core_req_o.addr == {$past(wb_dat_i[7:2]), 2'b00};
    endproperty
    a_req_launch: assert property (p_req_launch)
        else $error("Request write did not launch the selected read.");
    property p_req_zero; zero_wr && idle |=> !core_req_o.valid; endproperty
    a_req_zero: assert property (p_req_zero)
        else $error("Writing zero launched a read.");
    property p_valid_hold;
        core_req_o.valid && !core_rsp_i.ack && !abort_wr |=> core_req_o.valid;
    endproperty
    a_valid_hold: assert property (p_valid_hold)
        else $error("Core request dropped before its answer.");
    property p_addr_stable;
        core_req_o.valid && $past(core_req_o.valid)
            |-> $stable(core_req_o.addr);
    endproperty
    a_addr_stable: assert property (p_addr_stable)
        else $error("Core address moved during a read.");
    property p_done_drop; done |=> !core_req_o.valid; endproperty
    a_done_drop: assert property (p_done_drop)
        else $error("Core request stayed up after completion.");
    property p_result; res_rd |=> wb_dat_o == last_q; endproperty
    a_result: assert property (p_result)
        else $error("Result register differs from last completed read.");
    property p_abort_stop; abort_wr |=> (!core_req_o.valid)[*3]; endproperty
    a_abort_stop: assert property (p_abort_stop)
        else $error("Abort did not cancel the core request.");
    property p_abort_len;
        abort_wr |=> core_req_o.cancel[*2] ##1 !core_req_o.cancel;
    endproperty
    a_abort_len: assert property (p_abort_len)
        else $error("Cancel did not last two cycles and end.");

    c_launch: cover property (start_wr && idle);
    c_abort_busy: cover property (abort_wr && core_req_o.valid);
    c_done: cover property (done);
endmodule

// *** dmarr_top_bench.sv ***
// Self-checking bench for the DMA register read-request port.
`timescale 1ns/10ps
module dmarr_top_bench
    import dmarr_pkg::*;
;
    typedef struct packed {
        logic [5:0]  sel;
        logic [31:0] data;
        logic [3:0]  lag;
        logic        badsel;
    } dmarr_row_s;

    logic            clk_i       = 1'b0;
    logic            rstn_i      = 1'b0;
    logic            wb_cyc_i    = 1'b0;
    logic            wb_stb_i    = 1'b0;
    logic            wb_we_i     = 1'b0;
    logic [7:0]      wb_adr_i    = 8'h00;
    logic [3:0]      wb_sel_i    = 4'h0;
    logic [31:0]     wb_dat_i    = 32'h0;
    logic [31:0]     wb_dat_o;
    logic            wb_ack_o;
    dmarr_core_req_s core_req_o;
    dmarr_core_rsp_s core_rsp_i  = '0;
    int              bad_count   = 0;
    int              checks_done = 0;
    logic [31:0]     rd;
    logic [31:0]     sel_w;
    // Each row: selector, core data, answer lag, bad-selector flag.
    // rows 0 to 2 permitted
    dmarr_row_s      rows [4]    = '{
        '{DMARR_TGT_MW_ADDR[7:2], 32'h1234_5678, 4'h0, 1'b0},
        '{DMARR_TGT_MR_ADDR[7:2], 32'hA5A5_0F0F, 4'h3, 1'b0},
        '{DMARR_TGT_TIMEOUT[7:2], 32'hFFFF_FFFF, 4'h9, 1'b0},
        '{6'h3F, 32'h0000_0001, 4'h1, 1'b1}};

    // ----------------------------------------------------------------
    // Clock, design and helpers
    // ----------------------------------------------------------------
    always #5 clk_i = ~clk_i;

    dmarr_top DUT (.clk_i(clk_i), .rstn_i(rstn_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .core_req_o(core_req_o),
        .core_rsp_i(core_rsp_i));

    // Compare one value and count the outcome.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    // One classic Wishbone cycle, entered and left just after an edge.
    task automatic wb(input logic we, input logic [7:0] adr,
                      input logic [31:0] dat);
        int n;
        n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_sel_i <= 4'hF;
        wb_dat_i <= dat;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) chk({31'h0, wb_ack_o}, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    // Read one register and compare it.
    task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
        wb(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask

    // Core side answers after a lag with a one-cycle ack, then scrambles.
    task automatic core_ans(input logic [3:0] lag, input logic [31:0] d);
        repeat (lag) @(posedge clk_i);
        core_rsp_i <= '{ack: 1'b1, data: d};
        @(posedge clk_i);
        core_rsp_i <= '{ack: 1'b0, data: ~d};
    endtask

    // Print the counts and the verdict, then stop.
    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial begin
        repeat (16) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        foreach (rows[i]) begin
            sel_w = {24'h0, rows[i].sel, 2'b00};
            wb(1'b1, DMARR_OFS_REQUEST, 32'h8000_0000 | sel_w);
            chk({22'h0, core_req_o}, 32'h200 | sel_w);
            rchk(DMARR_OFS_REQUEST, 32'h8000_0000 | sel_w);
            core_ans(rows[i].lag, rows[i].data);
            rchk(DMARR_OFS_REQUEST, sel_w);
            rchk(DMARR_OFS_RESULT, rows[i].data);
            rchk(DMARR_OFS_STATUS, {30'h0, rows[i].badsel, 1'b1});
            wb(1'b1, DMARR_OFS_STATUS, 32'h3);
            rchk(DMARR_OFS_STATUS, 32'h0);
            $display("row %0d finished", i);
        end
        // Abort in mid-read; a late core answer must change nothing.
        wb(1'b1, DMARR_OFS_REQUEST, 32'h8000_0048);
        rchk(DMARR_OFS_REQUEST, 32'h8000_0048);
        wb(1'b1, DMARR_OFS_REQUEST, 32'h4000_0048);
        chk({31'h0, core_req_o.valid}, 32'h0);
        core_ans(4'h0, 32'hDEAD_BEEF);
        rchk(DMARR_OFS_REQUEST, 32'h0000_0048);
        rchk(DMARR_OFS_RESULT, rows[3].data);
        rchk(DMARR_OFS_STATUS, 32'h0);
        $display("abort test finished");
        // Writing zero to the request bit only stores the selector.
        wb(1'b1, DMARR_OFS_REQUEST, 32'h0000_0058);
        chk({31'h0, core_req_o.valid}, 32'h0);
        rchk(DMARR_OFS_REQUEST, 32'h0000_0058);
        rchk(8'hFC, 32'h0);
        $display("no-op write test finished");
        // Second reset in mid-run restores the reset values.
        rstn_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rchk(DMARR_OFS_REQUEST, DMARR_RST_REQUEST);
        rchk(DMARR_OFS_RESULT, DMARR_RST_RESULT);
        $display("reset test finished");
        finish_test();
    end

    // Cut a hang short; the tests need well under 1000 cycles.
    initial begin
        repeat (5000) @(posedge clk_i);
        bad_count++;
        finish_test();
    end
endmodule

bind dmarr_top dmarr_top_checker u_chk (.clk_i(clk_i), .rstn_i(rstn_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .core_req_o(core_req_o),
    .core_rsp_i(core_rsp_i));
